// ==== rtl/pipe_irq_defs.svh ====
// timing and layout constants for the pipeline interrupt controller
`ifndef PIPE_IRQ_DEFS_SVH
`define PIPE_IRQ_DEFS_SVH
`define PIPE_STAGES      8
`define PIPE_DEC2_IDX    3
`define PIPE_PC_W        16
`define PIPE_INSN_W      16
`define PIPE_VEC_RST     16'h0100
`define PIPE_PC_RST      16'h0000
`endif

// ==== rtl/pipe_irq_pkg.sv ====
// types shared by the pipeline interrupt controller
package pipe_irq_pkg;
	typedef enum logic [2:0]
	{
		ST_RUN   = 3'b001,
		ST_SERVE = 3'b010,
		ST_RET   = 3'b100
	} irq_state_type;
endpackage

// ==== rtl/pipe_stage_reg.sv ====
// one pipeline stage slot: valid, pc and instruction word
`timescale 1ns/100ps
`include "pipe_irq_defs.svh"
module pipe_stage_reg
(
	// clock and reset
	input  wire logic                     sys_clk_i,
	input  wire logic                     sys_rst_i,
	// slot input
	input  wire logic                     flush_i,
	input  wire logic                     vld_i,
	input  wire logic [`PIPE_PC_W-1:0]   pc_i,
	input  wire logic [`PIPE_INSN_W-1:0] insn_i,
	// slot output
	output logic                          vld_o,
	output logic [`PIPE_PC_W-1:0]        pc_o,
	output logic [`PIPE_INSN_W-1:0]      insn_o
);
	logic                     vld_next;
	logic [`PIPE_PC_W-1:0]   pc_next;
	logic [`PIPE_INSN_W-1:0] insn_next;

	// a flushed slot drops its instruction so it never takes effect
	always_comb
	begin
		vld_next  = vld_i & ~flush_i;
		pc_next   = pc_i;
		insn_next = insn_i;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			vld_o  <= 1'b0;
			pc_o   <= `PIPE_PC_RST;
			insn_o <= 16'h0000;
		end
		else
		begin
			vld_o  <= vld_next;
			pc_o   <= pc_next;
			insn_o <= insn_next;
		end
	end
endmodule // pipe_stage_reg

// ==== rtl/pipe_irq_ctrl.sv ====
// eight-stage pipeline with deterministic interrupt flush and refetch
`timescale 1ns/100ps
`include "pipe_irq_defs.svh"
// Notes on behaviour
// - eight fixed stages, fetch first, decode two
// - instructions in decode two always complete
// - stages before decode two flushed on accept
// - return restarts fetching at the first stage
// - other requests pend until service completes, unless nest_en_i is set
module pipe_irq_ctrl
(
	// clock and reset
	input  wire logic                     sys_clk_i,
	input  wire logic                     sys_rst_i,
	// interrupt requests and control
	input  wire logic                     irq_req_i,
	input  wire logic                     irq_ret_i,
	input  wire logic                     nest_en_i,
	// fetch memory
	input  wire logic [`PIPE_INSN_W-1:0] fetch_data_i,
	output logic [`PIPE_PC_W-1:0]        fetch_addr_o,
	// status
	output logic                          irq_ack_o,
	output logic                          irq_busy_o,
	output logic                          retire_vld_o,
	output logic [`PIPE_PC_W-1:0]        retire_pc_o,
	output logic [`PIPE_INSN_W-1:0]      retire_insn_o
);
	import pipe_irq_pkg::*;

	localparam int NS = `PIPE_STAGES;
	localparam int DEC2 = `PIPE_DEC2_IDX;

	// pin inputs pass two flops before use
	logic [2:0] sync1_reg;
	logic [2:0] sync2_reg;
	logic       req_s;
	logic       ret_s;
	logic       nest_s;

	irq_state_type             state_reg, state_next;
	logic [`PIPE_PC_W-1:0]     pc_reg, pc_next;
	logic [`PIPE_PC_W-1:0]     resume_reg, resume_next;
	logic                      ack_reg, ack_next;
	logic                      ack_d_reg, ack_d_next;
	logic                      accept;
	logic                      ret_take;
	logic                      flush_early;

	logic [NS:0]               vld_w;
	logic [`PIPE_PC_W-1:0]     pc_w   [0:NS];
	logic [`PIPE_INSN_W-1:0]   insn_w [0:NS];

	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
		end
		else
		begin
			sync1_reg <= {nest_en_i, irq_ret_i, irq_req_i};
			sync2_reg <= sync1_reg;
		end
	end

	assign req_s  = sync2_reg[0];
	assign ret_s  = sync2_reg[1];
	assign nest_s = sync2_reg[2];

	// a held level request stays pending until the state allows it; the source drops
	// it on the ack, but the sync still shows it for two cycles, so those are skipped
	// or a nesting service would take the same request twice
	assign accept      = req_s & ~ack_reg & ~ack_d_reg
		& ((state_reg == ST_RUN) | ((state_reg == ST_SERVE) & nest_s));
	// handler words fetched past the return point must not run either
	assign ret_take    = (state_reg == ST_SERVE) & ~accept & ret_s;
	assign flush_early = accept | ret_take;

	// controller state and fetch pointer
	always_comb
	begin
		state_next  = state_reg;
		pc_next     = pc_reg + 16'h0001;
		resume_next = resume_reg;
		ack_next    = 1'b0;
		ack_d_next  = ack_reg;
		case (state_reg)
			ST_RUN:
			begin
				if (accept)
				begin
					// oldest flushed pc; right after a return the slot ahead of
					// decode two may be empty, so look one slot further back
					if (vld_w[DEC2-1])
						resume_next = pc_w[DEC2-1];
					else if (vld_w[DEC2-2])
						resume_next = pc_w[DEC2-2];
					else
						resume_next = pc_reg;
					pc_next     = `PIPE_VEC_RST;
					ack_next    = 1'b1;
					state_next  = ST_SERVE;
				end
			end
			ST_SERVE:
			begin
				if (accept)
				begin
					// nesting only when software allows it; return target kept simple
					pc_next  = `PIPE_VEC_RST;
					ack_next = 1'b1;
				end
				else if (ret_s)
				begin
					pc_next    = resume_reg;
					state_next = ST_RET;
				end
			end
			ST_RET:
			begin
				state_next = ST_RUN;
			end
			default:
			begin
				state_next = ST_RUN;
				pc_next    = `PIPE_PC_RST;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			state_reg  <= ST_RUN;
			pc_reg     <= `PIPE_PC_RST;
			resume_reg <= `PIPE_PC_RST;
			ack_reg    <= 1'b0;
			ack_d_reg  <= 1'b0;
		end
		else
		begin
			state_reg  <= state_next;
			pc_reg     <= pc_next;
			resume_reg <= resume_next;
			ack_reg    <= ack_next;
			ack_d_reg  <= ack_d_next;
		end
	end

	// stage zero input is the fetch; the accept or return flush also drops a fetch in flight
	assign vld_w[0]  = 1'b1;
	assign pc_w[0]   = pc_reg;
	assign insn_w[0] = fetch_data_i;

	genvar g;
	generate
		for (g = 0; g < NS; g++)
		begin : g_stage
			pipe_stage_reg u_stage
			(
				.sys_clk_i (sys_clk_i),
				.sys_rst_i (sys_rst_i),
				// only slots ahead of decode two are flushed
				.flush_i   ((g < DEC2) ? flush_early : 1'b0),
				.vld_i     (vld_w[g]),
				.pc_i      (pc_w[g]),
				.insn_i    (insn_w[g]),
				.vld_o     (vld_w[g+1]),
				.pc_o      (pc_w[g+1]),
				.insn_o    (insn_w[g+1])
			);
		end
	endgenerate

	// registered outputs
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			fetch_addr_o  <= `PIPE_PC_RST;
			irq_busy_o    <= 1'b0;
			retire_vld_o  <= 1'b0;
			retire_pc_o   <= `PIPE_PC_RST;
			retire_insn_o <= 16'h0000;
		end
		else
		begin
			fetch_addr_o  <= pc_next;
			irq_busy_o    <= (state_next != ST_RUN);
			retire_vld_o  <= vld_w[NS];
			retire_pc_o   <= pc_w[NS];
			retire_insn_o <= insn_w[NS];
		end
	end
	assign irq_ack_o = ack_reg;

	// checks
	// a taken request, and the front of the pipe empty one edge later
	sequence s_accept;
		accept;
	endsequence

	sequence s_front_empty;
		!vld_w[1] && !vld_w[2] && !vld_w[DEC2];
	endsequence

	a_dec2_survives: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(accept && vld_w[DEC2])
		|=> vld_w[DEC2+1] && (pc_w[DEC2+1] == $past(pc_w[DEC2])))
		else $error("decode two instruction lost on interrupt");
	a_early_flush: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		s_accept |=> s_front_empty)
		else $error("early stage not flushed");
	a_ret_flush: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		ret_take |=> s_front_empty)
		else $error("handler words not dropped on return");
	a_no_nest: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(state_reg == ST_SERVE && !nest_s) |=> !irq_ack_o)
		else $error("request taken during service");
	a_ack_once: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		irq_ack_o |=> !irq_ack_o)
		else $error("one request taken twice");
	a_refetch_pc: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		ret_take |=> (pc_reg == $past(resume_reg)) && (fetch_addr_o == $past(resume_reg)))
		else $error("return did not refetch");
	a_ack_busy: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		s_accept |=> irq_ack_o && irq_busy_o)
		else $error("busy not shown after accept");
	a_retire_lat: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		vld_w[DEC2+1] |-> ##5 retire_vld_o)
		else $error("stage depth wrong");
endmodule // pipe_irq_ctrl

// ==== verification/fetch_mem_model.sv ====
// combinational instruction memory standing at the fetch side
`timescale 1ns/100ps
`include "pipe_irq_defs.svh"
module fetch_mem_model
(
	// fetch address in
	input  wire logic [`PIPE_PC_W-1:0]   addr_i,
	// instruction word out
	output logic      [`PIPE_INSN_W-1:0] data_o
);
	// word differs per address so a wrong pc shows in the data
	assign data_o = {addr_i[7:0] ^ 8'h5A, ~addr_i[15:8]};
endmodule // fetch_mem_model

// ==== verification/tb_cpu_pipeline_interrupt_flush.sv ====
// self-checking bench for the pipeline interrupt controller
`timescale 1ns/100ps
`include "pipe_irq_defs.svh"
module tb_cpu_pipeline_interrupt_flush;
	logic                    sys_clk_i = 1'b0;
	logic                    sys_rst_i = 1'b1;
	logic                    irq_req_i = 1'b0;
	logic                    irq_ret_i = 1'b0;
	logic                    nest_en_i = 1'b0;
	logic                    irq_ack_o, irq_busy_o, retire_vld_o;
	logic [`PIPE_PC_W-1:0]   fetch_addr_o, retire_pc_o;
	logic [`PIPE_PC_W-1:0]   last_main = 16'hFFFF;
	logic [`PIPE_PC_W-1:0]   last_vec = 16'h00FF;
	logic [`PIPE_INSN_W-1:0] fetch_data_i, retire_insn_o;
	int                      n_errors = 0;
	int                      checks_done = 0;
	int                      n_vec = 0;
	int                      n_entry = 0;
	pipe_irq_ctrl dut_u (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .irq_req_i(irq_req_i),
		.irq_ret_i(irq_ret_i), .nest_en_i(nest_en_i), .fetch_data_i(fetch_data_i),
		.fetch_addr_o(fetch_addr_o), .irq_ack_o(irq_ack_o), .irq_busy_o(irq_busy_o),
		.retire_vld_o(retire_vld_o), .retire_pc_o(retire_pc_o), .retire_insn_o(retire_insn_o));
	fetch_mem_model mem_u (.addr_i(fetch_addr_o), .data_o(fetch_data_i));
	// free-running core clock, 100 ns period
	always #50 sys_clk_i = ~sys_clk_i;
	task check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task results;
		if (n_errors == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// inputs move just after the edge so the design samples them cleanly
	task tick;
		@(posedge sys_clk_i);
		#1;
	endtask
	task wait_ack(output int n);
		n = 0;
		do
		begin
			tick();
			n++;
		end
		while (irq_ack_o !== 1'b1 && n < 40);
		if (n >= 40)
		begin
			n_errors++;
			results();
		end
	endtask
	// retire stream, read mid-cycle: main code and handler each advance by one;
	// the handler may restart at the vector once for every ack seen, since the
	// tail of an earlier service can still retire after a later ack
	always @(negedge sys_clk_i)
		if (!sys_rst_i)
		begin
			if (irq_ack_o === 1'b1)
				n_entry++;
			if (retire_vld_o === 1'b1)
			begin
				check(retire_insn_o, {retire_pc_o[7:0] ^ 8'h5A, ~retire_pc_o[15:8]});
				if (retire_pc_o < `PIPE_VEC_RST)
				begin
					check(retire_pc_o, last_main + 16'h0001);
					last_main = retire_pc_o;
				end
				else
				begin
					if (retire_pc_o == `PIPE_VEC_RST && n_entry > 0)
					begin
						n_entry--;
						last_vec = `PIPE_VEC_RST - 16'h0001;
					end
					check(retire_pc_o, last_vec + 16'h0001);
					last_vec = retire_pc_o;
					n_vec++;
				end
			end
		end
	// one service; with pend a second request must wait for the return
	task serve(input bit pend);
		int n;
		logic [15:0] saved;
		irq_req_i = 1'b1;
		wait_ack(n);
		check(16'(n), 16'h0003);
		check({15'h0, irq_busy_o}, 16'h0001);
		irq_req_i = 1'b0;
		repeat (4) tick();
		irq_req_i = pend;
		repeat (12)
		begin
			tick();
			check({15'h0, irq_ack_o}, 16'h0000);
		end
		saved = last_main;
		irq_ret_i = 1'b1;
		tick();
		irq_ret_i = 1'b0;
		if (pend)
		begin
			wait_ack(n);
			irq_req_i = 1'b0;
			repeat (12) tick();
			irq_ret_i = 1'b1;
			tick();
			irq_ret_i = 1'b0;
		end
		n = 0;
		while (irq_busy_o !== 1'b0 && n < 10)
		begin
			tick();
			n++;
		end
		check({15'h0, n < 10}, 16'h0001);
		repeat (20) tick();
		check({15'h0, last_main > saved}, 16'h0001);
		check({15'h0, n_vec != 0}, 16'h0001);
		check(16'(n_entry), 16'h0000);
	endtask
	// nesting allowed: a second request is taken inside the first service,
	// the first one is never taken twice, and the return goes to main code
	task serve_nest;
		int n;
		logic [15:0] saved;
		nest_en_i = 1'b1;
		irq_req_i = 1'b1;
		wait_ack(n);
		irq_req_i = 1'b0;
		saved = last_main;
		repeat (4)
		begin
			tick();
			check({15'h0, irq_ack_o}, 16'h0000);
		end
		irq_req_i = 1'b1;
		wait_ack(n);
		check(16'(n), 16'h0003);
		check({15'h0, irq_busy_o}, 16'h0001);
		irq_req_i = 1'b0;
		nest_en_i = 1'b0;
		repeat (12) tick();
		irq_ret_i = 1'b1;
		tick();
		irq_ret_i = 1'b0;
		n = 0;
		while (irq_busy_o !== 1'b0 && n < 10)
		begin
			tick();
			n++;
		end
		check({15'h0, n < 10}, 16'h0001);
		repeat (20) tick();
		check({15'h0, last_main > saved}, 16'h0001);
		check(16'(n_entry), 16'h0000);
	endtask
	initial
	begin
		repeat (3) tick();
		sys_rst_i = 1'b0;
		repeat (30) tick();
		serve(1'b0);
		serve(1'b1);
		serve_nest();
		results();
	end
endmodule // tb_cpu_pipeline_interrupt_flush
